// ===== design/pmr_avg.sv
`timescale 1ns/10ps
module pmr_avg #(
    parameter int W      = 16,
    parameter bit SIGNED = 1'b1
) (
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         reset_n,
    // Sample stream
    input  wire logic         clear,
    input  wire logic         take,
    input  wire logic         last,
    input  wire logic [3:0]   shift,
    input  wire logic [W-1:0] sample,
    // Result
    output logic      [W-1:0] avg_q
);
    localparam int AW = W + 11;

    logic signed [AW-1:0] acc_q;
    logic signed [AW-1:0] acc_d;
    logic        [W-1:0]  avg_d;
    logic signed [AW-1:0] ext;
    logic signed [AW-1:0] sum;

    initial begin
        if (W < 2) begin
            $error("pmr_avg: width too small");
        end
    end

    always_comb begin
        ext   = SIGNED ? AW'(signed'(sample)) : AW'(sample);
        sum   = acc_q + ext;
        acc_d = acc_q;
        avg_d = avg_q;
        if (clear) begin
            acc_d = '0;
        end else if (take) begin
            if (last) begin
                // Power-of-two counts, so the mean is an arithmetic shift
                avg_d = W'(sum >>> shift);
                acc_d = '0;
            end else begin
                acc_d = sum;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            acc_q <= '0;
            avg_q <= '0;
        end else begin
            acc_q <= acc_d;
            avg_q <= avg_d;
        end
    end
endmodule

// ===== design/pmr_core.sv
`timescale 1ns/10ps
`include "pmr_defs.svh"
module pmr_core #(
    parameter int CYC_PER_US = `PMR_CYC_PER_US
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             reset_n,
    // Register port from the serial front end
    input  wire logic             reg_wr_en,
    input  wire logic [7:0]       reg_addr,
    input  wire pmr_pkg::pmr_word_t reg_wdata,
    output pmr_pkg::pmr_word_t    reg_rd_data,
    // Converter words
    input  wire logic [15:0]      shunt_drop_reading,
    input  wire logic [14:0]      rail_voltage_reading,
    output logic                  sense_take,
    output logic                  bus_take,
    // Status
    output logic                  conv_busy,
    output logic                  conv_ready
);
    import pmr_pkg::*;

    initial begin
        if (CYC_PER_US < 1 || CYC_PER_US > 1024) begin
            $error("pmr_core: CYC_PER_US out of range");
        end
    end

    pmr_state_t state_q, state_d;
    pmr_word_t  cfg_q, cfg_d, cal_q, cal_d;
    pmr_word_t  sense_q, sense_d, bus_q, bus_d, cur_q, cur_d, pwr_q, pwr_d, rd_q, rd_d;
    logic [9:0]  div_q, div_d;
    logic [13:0] us_q, us_d;
    logic [9:0]  n_q, n_d;
    logic        restart_q, restart_d;
    logic        stake_q, stake_d, btake_q, btake_d, busy_q, busy_d, ready_q, ready_d;

    logic        us_tick, ct_done, last, clear, s_take, b_take;
    logic        meas_s, meas_b, cont, shut;
    logic [3:0]  avg_sh;
    logic [13:0] ct_us;
    logic [31:0] cur_prod, pwr_prod;
    pmr_word_t   cur_calc, pwr_calc, cur_abs, s_avg, b_avg;

    function automatic logic [13:0] ct_lookup(input logic [2:0] sel);
        case (sel)
            3'd0:    ct_lookup = `PMR_CT0_US;
            3'd1:    ct_lookup = `PMR_CT1_US;
            3'd2:    ct_lookup = `PMR_CT2_US;
            3'd3:    ct_lookup = `PMR_CT3_US;
            3'd4:    ct_lookup = `PMR_CT4_US;
            3'd5:    ct_lookup = `PMR_CT5_US;
            3'd6:    ct_lookup = `PMR_CT6_US;
            default: ct_lookup = `PMR_CT7_US;
        endcase
    endfunction

    function automatic logic [3:0] avg_lookup(input logic [2:0] sel);
        case (sel)
            3'd0:    avg_lookup = 4'd0;
            3'd1:    avg_lookup = 4'd2;
            3'd2:    avg_lookup = 4'd4;
            3'd3:    avg_lookup = 4'd6;
            3'd4:    avg_lookup = 4'd7;
            3'd5:    avg_lookup = 4'd8;
            3'd6:    avg_lookup = 4'd9;
            default: avg_lookup = 4'd10;
        endcase
    endfunction

    // Mode decode
    assign meas_s = cfg_q[0];
    assign meas_b = cfg_q[1];
    assign cont   = cfg_q[2];
    assign shut   = (cfg_q[1:0] == 2'b00);
    assign avg_sh = avg_lookup(cfg_q[`PMR_AVG_HI:`PMR_AVG_LO]);
    assign ct_us  = (state_q == PMR_BUS) ? ct_lookup(cfg_q[`PMR_BCT_HI:`PMR_BCT_LO])
                                         : ct_lookup(cfg_q[`PMR_SCT_HI:`PMR_SCT_LO]);
    assign us_tick = (div_q == 10'(CYC_PER_US - 1));
    assign ct_done = us_tick && (us_q == ct_us - 14'd1);
    assign last    = ({1'b0, n_q} == ((11'd1 << avg_sh) - 11'd1));
    assign s_take  = (state_q == PMR_SENSE) && ct_done;
    assign b_take  = (state_q == PMR_BUS) && ct_done;

    // Current and power from the published results
    // Both factors widened first so the product keeps all 32 bits
    assign cur_prod = 32'(signed'(sense_q)) * 32'(signed'({1'b0, cal_q[14:0]}));
    assign cur_calc = cur_prod[`PMR_CUR_SHIFT+15:`PMR_CUR_SHIFT];
    assign cur_abs  = cur_calc[15] ? 16'(-cur_calc) : cur_calc;
    assign pwr_prod = cur_abs * bus_q;
    assign pwr_calc = pwr_prod[`PMR_PWR_SHIFT+15:`PMR_PWR_SHIFT];

    pmr_avg #(.W(16), .SIGNED(1'b1)) u_sense_avg (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .clear   (clear),
        .take    (s_take),
        .last    (last),
        .shift   (avg_sh),
        .sample  (shunt_drop_reading),
        .avg_q   (s_avg)
    );

    pmr_avg #(.W(16), .SIGNED(1'b0)) u_bus_avg (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .clear   (clear),
        .take    (b_take),
        .last    (last),
        .shift   (avg_sh),
        .sample  ({1'b0, rail_voltage_reading}),
        .avg_q   (b_avg)
    );

    always_comb begin
        state_d   = state_q;
        cfg_d     = cfg_q;
        cal_d     = cal_q;
        sense_d   = sense_q;
        bus_d     = bus_q;
        cur_d     = cur_q;
        pwr_d     = pwr_q;
        div_d     = us_tick ? 10'd0 : div_q + 10'd1;
        us_d      = us_q;
        n_d       = n_q;
        restart_d = restart_q;
        stake_d   = s_take;
        btake_d   = b_take;
        ready_d   = 1'b0;
        clear     = 1'b0;
        if (us_tick) begin
            us_d = us_q + 14'd1;
        end
        unique case (state_q)
            PMR_IDLE, PMR_HOLD: begin
                if (restart_q) begin
                    restart_d = 1'b0;
                    div_d     = '0;
                    us_d      = '0;
                    n_d       = '0;
                    clear     = 1'b1;
                    if (!shut) begin
                        state_d = meas_s ? PMR_SENSE : PMR_BUS;
                    end
                end
            end
            PMR_SENSE, PMR_BUS: begin
                if (ct_done) begin
                    us_d = '0;
                    if (state_q == PMR_SENSE && meas_b) begin
                        state_d = PMR_BUS;
                    end else if (last) begin
                        state_d = PMR_CALC;
                    end else begin
                        n_d     = n_q + 10'd1;
                        state_d = meas_s ? PMR_SENSE : PMR_BUS;
                    end
                end
            end
            PMR_CALC: begin
                if (meas_s) begin
                    sense_d = s_avg;
                end
                if (meas_b) begin
                    bus_d = {1'b0, b_avg[14:0]};
                end
                state_d = PMR_PWR;
            end
            PMR_PWR: begin
                cur_d   = cur_calc;
                pwr_d   = pwr_calc;
                ready_d = 1'b1;
                if (cont) begin
                    restart_d = 1'b1;
                    state_d   = PMR_IDLE;
                end else begin
                    state_d = PMR_HOLD;
                end
            end
        endcase
        // Configuration write wins: abort whatever runs and restart next cycle
        if (reg_wr_en) begin
            if (reg_addr == `PMR_OFF_CFG) begin
                state_d   = PMR_IDLE;
                restart_d = 1'b1;
                clear     = 1'b1;
                stake_d   = 1'b0;
                btake_d   = 1'b0;
                ready_d   = 1'b0;
                if (reg_wdata[`PMR_CFG_RST_BIT]) begin
                    cfg_d   = `PMR_CFG_RESET;
                    cal_d   = '0;
                    sense_d = '0;
                    bus_d   = '0;
                    cur_d   = '0;
                    pwr_d   = '0;
                end else begin
                    cfg_d = reg_wdata & `PMR_CFG_WMASK;
                end
            end else if (reg_addr == `PMR_OFF_CAL) begin
                cal_d = reg_wdata & `PMR_CAL_WMASK;
            end
        end
        busy_d = (state_d != PMR_IDLE) && (state_d != PMR_HOLD);
        case (reg_addr)
            `PMR_OFF_CFG:   rd_d = cfg_d;
            `PMR_OFF_SENSE: rd_d = sense_d;
            `PMR_OFF_BUS:   rd_d = bus_d;
            `PMR_OFF_PWR:   rd_d = pwr_d;
            `PMR_OFF_CUR:   rd_d = cur_d;
            `PMR_OFF_CAL:   rd_d = cal_d;
            default:        rd_d = '0;
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q   <= PMR_IDLE;
            cfg_q     <= `PMR_CFG_RESET;
            cal_q     <= '0;
            sense_q   <= '0;
            bus_q     <= '0;
            cur_q     <= '0;
            pwr_q     <= '0;
            rd_q      <= '0;
            div_q     <= '0;
            us_q      <= '0;
            n_q       <= '0;
            restart_q <= 1'b1;
            stake_q   <= 1'b0;
            btake_q   <= 1'b0;
            busy_q    <= 1'b0;
            ready_q   <= 1'b0;
        end else begin
            state_q   <= state_d;
            cfg_q     <= cfg_d;
            cal_q     <= cal_d;
            sense_q   <= sense_d;
            bus_q     <= bus_d;
            cur_q     <= cur_d;
            pwr_q     <= pwr_d;
            rd_q      <= rd_d;
            div_q     <= div_d;
            us_q      <= us_d;
            n_q       <= n_d;
            restart_q <= restart_d;
            stake_q   <= stake_d;
            btake_q   <= btake_d;
            busy_q    <= busy_d;
            ready_q   <= ready_d;
        end
    end

    assign reg_rd_data = rd_q;
    assign sense_take  = stake_q;
    assign bus_take    = btake_q;
    assign conv_busy   = busy_q;
    assign conv_ready  = ready_q;

    chk_cfg_default: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !$past(reset_n) |-> cfg_q[2:0] == 3'b111)
        else $error("select field not continuous both after reset");

    chk_wr_abort: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (reg_wr_en && reg_addr == `PMR_OFF_CFG) |=> state_q == PMR_IDLE && restart_q)
        else $error("configuration write did not abort conversion");

    chk_wr_restart: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (reg_wr_en && reg_addr == `PMR_OFF_CFG && !reg_wdata[15]
         && reg_wdata[1:0] != 2'b00) ##1 !reg_wr_en
        |=> state_q == PMR_SENSE || state_q == PMR_BUS)
        else $error("no fresh conversion after configuration write");

    chk_shut_idle: assert property (@(posedge ref_clk) disable iff (!reset_n)
        cfg_q[1:0] == 2'b00 |-> state_q == PMR_IDLE)
        else $error("conversion running in shutdown");

    chk_trig_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (state_q == PMR_PWR && !cfg_q[2] && !reg_wr_en)
        |=> state_q == PMR_HOLD ##1 (state_q == PMR_HOLD || $past(reg_wr_en)))
        else $error("triggered select did not idle after one conversion");

    chk_sense_store: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (state_q == PMR_CALC && cfg_q[0] && !reg_wr_en) |=> sense_q == $past(s_avg))
        else $error("sense result not the averaged value");

    chk_bus_msb: assert property (@(posedge ref_clk) disable iff (!reset_n)
        bus_q[15] == 1'b0 && !(rd_q[15] && $past(reg_addr) == `PMR_OFF_BUS))
        else $error("bus result bit 15 set");

    chk_power_prod: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (ready_q && !$past(reg_wr_en)) |-> pwr_q == pwr_calc && cur_q == cur_calc)
        else $error("power or current not the product of results");

endmodule

// ===== inc/pmr_defs.svh
`ifndef PMR_DEFS_SVH
`define PMR_DEFS_SVH

`define PMR_OFF_CFG       8'h00
`define PMR_OFF_SENSE     8'h01
`define PMR_OFF_BUS       8'h02
`define PMR_OFF_PWR       8'h03
`define PMR_OFF_CUR       8'h04
`define PMR_OFF_CAL       8'h05

`define PMR_CFG_RESET     16'h4127
`define PMR_CFG_RST_BIT   15
`define PMR_CFG_WMASK     16'h7FFF
`define PMR_CAL_WMASK     16'h7FFF
`define PMR_AVG_HI        11
`define PMR_AVG_LO        9
`define PMR_BCT_HI        8
`define PMR_BCT_LO        6
`define PMR_SCT_HI        5
`define PMR_SCT_LO        3

// Conversion times in microseconds, index is the three-bit time field
`define PMR_CT0_US        14'd139
`define PMR_CT1_US        14'd203
`define PMR_CT2_US        14'd269
`define PMR_CT3_US        14'd525
`define PMR_CT4_US        14'd1037
`define PMR_CT5_US        14'd2061
`define PMR_CT6_US        14'd4109
`define PMR_CT7_US        14'd8205

`define PMR_CLK_PERIOD_PS 4000
`define PMR_US_PS         1000000
`define PMR_CYC_PER_US    (`PMR_US_PS / `PMR_CLK_PERIOD_PS)

`define PMR_CUR_SHIFT     11
`define PMR_PWR_SHIFT     12

`endif

// ===== inc/pmr_pkg.sv
package pmr_pkg;

    // Gray along idle, sense, bus, calc, power, hold
    typedef enum logic [2:0] {
        PMR_IDLE  = 3'b000,
        PMR_SENSE = 3'b001,
        PMR_BUS   = 3'b011,
        PMR_CALC  = 3'b010,
        PMR_PWR   = 3'b110,
        PMR_HOLD  = 3'b111
    } pmr_state_t;

    typedef logic [15:0] pmr_word_t;

endpackage

// ===== tb/pmr_conv_model.sv
`timescale 1ns/10ps
module pmr_conv_model #(
    parameter logic [15:0] SENSE0 = 16'h8300,
    parameter logic [14:0] RAIL0  = 15'h1234
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    // Sample strobes from the block
    input  wire logic        sense_take,
    input  wire logic        bus_take,
    // Converter words and the values last taken
    output logic      [15:0] shunt_drop_reading,
    output logic      [14:0] rail_voltage_reading,
    output logic      [15:0] last_sense,
    output logic      [14:0] last_rail
);
    // Step of two keeps a four-sample mean exact
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            shunt_drop_reading <= SENSE0;
            rail_voltage_reading <= RAIL0;
            last_sense <= 16'h0000;
            last_rail <= 15'h0000;
        end else begin
            if (sense_take) begin
                last_sense <= shunt_drop_reading;
                shunt_drop_reading <= shunt_drop_reading + 16'h0002;
            end
            if (bus_take) begin
                last_rail <= rail_voltage_reading;
                rail_voltage_reading <= rail_voltage_reading + 15'h0002;
            end
        end
    end
endmodule

// ===== tb/tb_power_monitor_results_mode.sv
`timescale 1ns/10ps
`define CHK(g, e) begin \
    total_checks++; \
    if ((g) !== (e)) begin \
        n_fail++; \
        $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
end
module tb_power_monitor_results_mode;
    import pmr_pkg::*;
    localparam int        CYC   = 2;
    localparam int        LIMIT = 40000;
    localparam pmr_word_t CAL   = 16'h0800;
    logic        ref_clk   = 1'b0;
    logic        reset_n   = 1'b0;
    logic        reg_wr_en = 1'b0;
    logic [7:0]  reg_addr  = 8'h00;
    pmr_word_t   reg_wdata = 16'h0000;
    pmr_word_t   reg_rd_data;
    logic [15:0] shunt;
    logic [14:0] rail;
    logic [15:0] l_s;
    logic [14:0] l_r;
    logic        s_take;
    logic        b_take;
    logic        busy;
    logic        ready;
    int          n_fail = 0;
    int          total_checks = 0;
    int          cyc = 0;
    int          n_s = 0;
    int          n_b = 0;
    int          n_busy = 0;
    pmr_word_t   d;
    pmr_word_t   s0;
    logic [14:0] r0;

    always #2 ref_clk = ~ref_clk;

    pmr_core #(.CYC_PER_US(CYC)) dut (
        .ref_clk              (ref_clk),
        .reset_n              (reset_n),
        .reg_wr_en            (reg_wr_en),
        .reg_addr             (reg_addr),
        .reg_wdata            (reg_wdata),
        .reg_rd_data          (reg_rd_data),
        .shunt_drop_reading   (shunt),
        .rail_voltage_reading (rail),
        .sense_take           (s_take),
        .bus_take             (b_take),
        .conv_busy            (busy),
        .conv_ready           (ready)
    );

    pmr_conv_model conv (
        .ref_clk              (ref_clk),
        .reset_n              (reset_n),
        .sense_take           (s_take),
        .bus_take             (b_take),
        .shunt_drop_reading   (shunt),
        .rail_voltage_reading (rail),
        .last_sense           (l_s),
        .last_rail            (l_r)
    );

    task automatic finish_test();
        $display("checks=%0d failures=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Counts sample strobes and busy cycles; also cuts a hang short
    always @(posedge ref_clk) begin
        cyc++;
        n_s += int'(s_take);
        n_b += int'(b_take);
        n_busy += int'(busy);
        if (cyc == LIMIT) begin
            n_fail++;
            finish_test();
        end
    end

    task automatic wr(input logic [7:0] a, input pmr_word_t v);
        @(posedge ref_clk);
        reg_wr_en <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_wr_en <= 1'b0;
    endtask

    task automatic chk_rd(input logic [7:0] a, input pmr_word_t e);
        @(posedge ref_clk);
        reg_addr <= a;
        @(posedge ref_clk);
        @(negedge ref_clk);
        d = reg_rd_data;
        `CHK(d, e)
    endtask

    task automatic wait_ready(input int lim);
        for (int i = 0; i < lim; i++) begin
            @(negedge ref_clk);
            if (ready === 1'b1) break;
        end
        `CHK(ready, 1'b1)
    endtask

    // Current keeps bits 26:11 of sense times cal, power bits 27:12
    function automatic pmr_word_t exp_pwr(input pmr_word_t s, input logic [14:0] b);
        logic signed [31:0] p;
        logic [15:0]        cur;
        logic [31:0]        q;
        p = $signed(s) * $signed({1'b0, CAL[14:0]});
        cur = p[26:11];
        if (cur[15]) cur = -cur;
        q = cur * b;
        return q[27:12];
    endfunction

    initial begin
        repeat (4) @(posedge ref_clk);
        reset_n <= 1'b1;
        chk_rd(8'h00, 16'h4127);
        wr(8'h05, CAL);
        s0 = shunt;
        r0 = rail;
        wr(8'h00, 16'h0003);
        wait_ready(1000);
        chk_rd(8'h01, s0);
        chk_rd(8'h02, {1'b0, r0});
        chk_rd(8'h03, exp_pwr(s0, r0));
        // Cal of 800h makes the current equal to the sense word
        chk_rd(8'h04, s0);
        n_s = 0;
        n_b = 0;
        n_busy = 0;
        repeat (700) @(posedge ref_clk);
        `CHK(n_s + n_b + n_busy, 0)
        for (int m = 0; m < 8; m++) begin
            wr(8'h00, {13'h0000, m[2:0]});
            repeat (2) @(negedge ref_clk);
            n_s = 0;
            n_b = 0;
            n_busy = 0;
            repeat (1400) @(posedge ref_clk);
            `CHK((n_s > 2) ? 2 : n_s, m[0] ? (m[2] ? 2 : 1) : 0)
            `CHK((n_b > 2) ? 2 : n_b, m[1] ? (m[2] ? 2 : 1) : 0)
            `CHK(n_busy > 0, m[1:0] != 2'b00)
            if (m == 2) chk_rd(8'h02, {1'b0, l_r});
        end
        // Stop first so the readings cannot move before the start
        wr(8'h00, 16'h0000);
        repeat (4) @(negedge ref_clk);
        s0 = shunt;
        r0 = rail;
        wr(8'h00, 16'h0203);
        wait_ready(3000);
        chk_rd(8'h01, s0 + 16'h0003);
        chk_rd(8'h02, {1'b0, r0 + 15'h0003});
        chk_rd(8'h03, exp_pwr(s0 + 16'h0003, r0 + 15'h0003));
        wr(8'h00, 16'h0007);
        for (int i = 0; i < 600; i++) begin
            @(negedge ref_clk);
            if (s_take === 1'b1) break;
        end
        // Rewrite mid bus conversion: the next sample must be a sense one
        wr(8'h00, 16'h0007);
        for (int i = 0; i < 1000; i++) begin
            @(negedge ref_clk);
            if (s_take === 1'b1 || b_take === 1'b1) break;
        end
        `CHK(s_take, 1'b1)
        `CHK(b_take, 1'b0)
        wr(8'h00, 16'h8000);
        chk_rd(8'h00, 16'h4127);
        chk_rd(8'h05, 16'h0000);
        wr(8'h01, 16'hFFFF);
        chk_rd(8'h01, 16'h0000);
        finish_test();
    end
endmodule
